// ### shared/bil_pkg.sv
package bil_pkg;
  // ==========================================================
  // Register map and security field layout
  localparam logic [3:0] REG_SEC  = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam logic [3:0] REG_CTRL = 4'h8;
  localparam int SEC_JTAG_OFF     = 0;
  localparam int SEC_LINK_OFF     = 1;
  localparam int SEC_OTP_BOOT     = 5;
  localparam int SEC_REDUND       = 7;
  localparam int SEC_LOCK_LSB     = 8;
  localparam int SEC_MASTER_LOCK  = 12;
  localparam int SEC_JTAG_OTP_OFF = 13;
  localparam int SEC_DEBUG_OFF    = 14;
  localparam int SEC_GP_LSB       = 15;
  localparam int SEC_GP_MSB       = 21;
  localparam int SEC_UID_LSB      = 22;
  localparam logic [31:0] SEC_RESET = 32'h0;
  // ==========================================================
  // Image, flash and link constants
  localparam logic [31:0] CRC_POLY  = 32'hEDB88320;
  localparam logic [31:0] CRC_INIT  = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_SKIP  = 32'h0D15AB1E;
  localparam logic [31:0] ACK_NULL  = 32'h0000FF02;
  localparam logic [31:0] BOOT_ADDR = 32'h0;
  localparam logic [7:0]  SPI_READ_CMD = 8'h03;
  localparam logic [23:0] SPI_ADDR0    = 24'h0;
  localparam logic [7:0]  TOK_END      = 8'h01;
  localparam logic [10:0] OTP_IMG_ROW  = 11'h0;
  localparam logic [10:0] OTP_SEC_ROW  = 11'h7FF;
  localparam logic [1:0]  STRAP_LINK   = 2'h2;
  localparam logic [1:0]  STRAP_SPI    = 2'h3;
  // ==========================================================
  // Timing: figures in their units, counts derived at 8 ns
  localparam int CLK_PS      = 8000;
  localparam int POR_NS      = 15000;
  localparam int LINK_EN_NS  = 200;
  localparam int SPI_SCK_KHZ = 2500;
  localparam logic [11:0] POR_CYC = 12'((POR_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam logic [11:0] LINK_EN_CYC = 12'((LINK_EN_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam logic [11:0] HALF_CYC = 12'(1000000000 / (2 * SPI_SCK_KHZ) / CLK_PS);
  // ==========================================================
  // Types
  typedef enum logic [13:0] {
    ST_POR    = 14'h0001, ST_SECLD  = 14'h0002, ST_DECIDE = 14'h0004,
    ST_IDLE   = 14'h0008, ST_SPI    = 14'h0010, ST_OTP    = 14'h0020,
    ST_LNKEN  = 14'h0040, ST_LNKACK = 14'h0080, ST_LNKIMG = 14'h0100,
    ST_LNKEND = 14'h0200, ST_LNKTX  = 14'h0400, ST_CHECK  = 14'h0800,
    ST_RUN    = 14'h1000, ST_FAIL   = 14'h2000
  } bil_state_t;
  typedef struct packed {
    logic       jtag_off;
    logic       link_off;
    logic       otp_redund;
    logic [3:0] sector_lock;
    logic       otp_master_lock;
    logic       jtag_otp_off;
    logic       debug_pin_off;
    logic [9:0] user_ext;
  } bil_sec_gate_t;
  typedef struct packed {
    logic        we;
    logic [13:0] addr;
    logic [31:0] data;
  } bil_ram_wr_t;
endpackage

// ### verilog/bil_boot_loader.sv
// Behaviour
// - Strap bits 3:2 pick boot: 00 JTAG wait, 01 reserved, 10 link, 11 SPI.
// - Security bit 5 forces boot from OTP address zero, ignoring straps.
// - Image is word count, count*4 bytes, CRC; 0x0D15AB1E skips check.
// - Count and CRC words are assembled least significant byte first.
// - Program words land from RAM address zero; execution starts there.
// - Reflected CRC-32, poly EDB88320, init all ones, inverted before compare.
// - Pins float in reset; pulls enabled and boot starts 15-150 us later.
// - SPI boot: device is master, clock 2.5 MHz, polarity 0, phase 0.
// - SPI boot sends READ and 24-bit zero address, then streams bytes.
// - Image bytes travel least significant bit first over SPI.
// - SPI boot uses fixed pins that software cannot reassign.
// - Link boot enables link 200 ns in: pulls off, tx low, rx watched.
// - Link order: alloc, ack word, image, END in, END out unless ack word is null, free, jump.
// - Bit 0 disables JTAG access; bit 1 blocks switch access from tiles.
// - Bit 7 redundant rows; bits 8-11 sector locks; bit 12 master lock.
// - Bit 13 blocks JTAG access to OTP; bit 14 disables debug pin.
// - Bits 15-21 software-readable field; bits 22-31 user code extension.
// - Security word is loaded from OTP before the boot source is chosen.
`timescale 1ns/1ps
module bil_boot_loader (
  // Clock, reset, enable
  input  wire logic                   clk_i,
  input  wire logic                   reset_n_i,
  input  wire logic                   clk_en_i,
  // Boot strap pins
  input  wire logic [1:0]             strap_mode_i,
  // Register port
  input  wire logic [3:0]             reg_addr_i,
  input  wire logic [31:0]            reg_wdata_i,
  input  wire logic                   reg_wr_i,
  input  wire logic                   reg_rd_i,
  output logic      [31:0]            reg_rdata_o,
  // OTP read port, data one cycle after read
  output logic                        otp_rd_o,
  output logic      [10:0]            otp_addr_o,
  input  wire logic [31:0]            otp_data_i,
  // RAM write port and core start
  output bil_pkg::bil_ram_wr_t        ram_wr_o,
  output logic                        core_start_o,
  output logic      [31:0]            core_pc_o,
  // Security gates
  output bil_pkg::bil_sec_gate_t      sec_gate_o,
  // Pad control
  output logic                        gpio_pull_en_o,
  output logic                        link_pd_en_o,
  // SPI boot pins
  input  wire logic                   spi_boot_miso_pin_i,
  output logic                        spi_boot_select_pin_o,
  output logic                        spi_boot_clock_pin_o,
  output logic                        spi_boot_mosi_pin_o,
  output logic                        spi_oe_o,
  // Link wires
  output logic                        link_tx_wire_0_o,
  output logic                        link_tx_wire_1_o,
  output logic                        link_tx_oe_o,
  input  wire logic                   link_rx_wire_0_i,
  input  wire logic                   link_rx_wire_1_i
);
  import bil_pkg::*;

  // ==========================================================
  // Declarations
  bil_state_t  state, next_state;
  logic [11:0] tmr;
  logic [31:0] sec;
  logic [1:0]  strap_s1, strap_s2;
  logic [2:0]  pin_s1, pin_s2;
  logic        rx1_prev, half_tick, kick;
  logic        byte_v, ld_done, chan_busy;
  logic [7:0]  byte_d;
  logic [1:0]  fld, bidx;
  logic [31:0] wsh, left, crc, img_crc, ack, txsh, owd;
  logic [13:0] ram_addr;
  logic [5:0]  txn;
  logic [2:0]  rxn, ackn, opos;
  logic [7:0]  rxsh;
  logic        spi_bv, sclk, tok_v, tok_ctl;
  logic [7:0]  spi_bd, tok_d;
  logic [8:0]  lr_sh, lt_sh;
  logic [3:0]  lr_n, lt_n;
  logic        lt_clk;
  logic [10:0] orow;

  // Reflected CRC-32 update by one byte
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h0, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // ==========================================================
  // Synchronisers for pins
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      strap_s1 <= 2'h0;
      strap_s2 <= 2'h0;
      pin_s1   <= 3'h0;
      pin_s2   <= 3'h0;
      rx1_prev <= 1'b0;
    end else if (clk_en_i) begin
      strap_s1 <= strap_mode_i;
      strap_s2 <= strap_s1;
      pin_s1   <= {link_rx_wire_1_i, link_rx_wire_0_i, spi_boot_miso_pin_i};
      pin_s2   <= pin_s1;
      rx1_prev <= pin_s2[2];
    end
  end

  // ==========================================================
  // Boot sequencer
  assign kick      = reg_wr_i && reg_addr_i == REG_CTRL && reg_wdata_i[0];
  assign half_tick = (state == ST_SPI || state == ST_LNKTX) && tmr == HALF_CYC - 12'h001;

  always_comb begin
    next_state = state;
    unique case (state)
      ST_POR:    if (tmr == POR_CYC - 12'h001) next_state = ST_SECLD;
      ST_SECLD:  if (tmr == 12'h001) next_state = ST_DECIDE;
      ST_DECIDE: begin
        if (sec[SEC_OTP_BOOT]) next_state = ST_OTP;
        else if (strap_s2 == STRAP_SPI) next_state = ST_SPI;
        else if (strap_s2 == STRAP_LINK) next_state = ST_LNKEN;
        else next_state = ST_IDLE;
      end
      ST_IDLE:   if (kick) next_state = ST_DECIDE;
      ST_SPI,
      ST_OTP:    if (ld_done && !sclk) next_state = ST_CHECK;
      ST_LNKEN:  if (tmr == LINK_EN_CYC - 12'h001) next_state = ST_LNKACK;
      ST_LNKACK: if (ackn == 3'h4) next_state = ST_LNKIMG;
      ST_LNKIMG: if (ld_done) next_state = ST_LNKEND;
      ST_LNKEND: begin
        if (tok_v && tok_ctl && tok_d == TOK_END) begin
          next_state = (ack == ACK_NULL) ? ST_CHECK : ST_LNKTX;
        end
      end
      ST_LNKTX:  if (half_tick && lt_clk && lt_n == 4'h8) next_state = ST_CHECK;
      ST_CHECK:  begin
        if (img_crc == CRC_SKIP || ~crc == img_crc) next_state = ST_RUN;
        else next_state = ST_FAIL;
      end
      ST_RUN:    next_state = ST_RUN;
      ST_FAIL:   next_state = ST_FAIL;
      default:   next_state = ST_FAIL;
    endcase
  end

  // State register and shared delay/divider timer
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state <= ST_POR;
      tmr   <= 12'h000;
    end else if (clk_en_i) begin
      state <= next_state;
      tmr   <= (next_state != state || half_tick) ? 12'h000 : tmr + 12'h001;
    end
  end

  // Pads: all floating in reset, pulls on after the POR delay, drivers enabled per source
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      gpio_pull_en_o <= 1'b0;
      link_pd_en_o   <= 1'b0;
      spi_oe_o       <= 1'b0;
      link_tx_oe_o   <= 1'b0;
      chan_busy      <= 1'b0;
    end else if (clk_en_i) begin
      if (state == ST_POR && next_state == ST_SECLD) gpio_pull_en_o <= 1'b1;
      if (state == ST_POR && next_state == ST_SECLD) link_pd_en_o <= 1'b1;
      if (next_state == ST_SPI) spi_oe_o <= 1'b1;
      if (state == ST_LNKEN && next_state == ST_LNKACK) begin
        link_pd_en_o <= 1'b0;
        link_tx_oe_o <= 1'b1;
        chan_busy    <= 1'b1;
      end
      if (next_state == ST_CHECK && (state == ST_LNKEND || state == ST_LNKTX)) chan_busy <= 1'b0;
    end
  end

  // ==========================================================
  // Security register
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      sec <= SEC_RESET;
    end else if (clk_en_i) begin
      if (state == ST_SECLD && tmr == 12'h001) sec <= otp_data_i;
      else if (reg_wr_i && reg_addr_i == REG_SEC) sec[SEC_GP_MSB:SEC_GP_LSB] <= reg_wdata_i[SEC_GP_MSB:SEC_GP_LSB];
    end
  end

  // Gates driven from the security word
  always_comb begin
    sec_gate_o.jtag_off        = sec[SEC_JTAG_OFF];
    sec_gate_o.link_off        = sec[SEC_LINK_OFF];
    sec_gate_o.otp_redund      = sec[SEC_REDUND];
    sec_gate_o.sector_lock     = sec[SEC_LOCK_LSB+:4] | {4{sec[SEC_MASTER_LOCK]}};
    sec_gate_o.otp_master_lock = sec[SEC_MASTER_LOCK];
    sec_gate_o.jtag_otp_off    = sec[SEC_JTAG_OTP_OFF];
    sec_gate_o.debug_pin_off   = sec[SEC_DEBUG_OFF];
    sec_gate_o.user_ext        = sec[31:SEC_UID_LSB];
  end

  // Register read, data one cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= 32'h0;
    end else if (clk_en_i) begin
      if (reg_rd_i) begin
        unique case (reg_addr_i)
          REG_SEC:  reg_rdata_o <= sec;
          REG_STAT: reg_rdata_o <= {13'h0, chan_busy, ld_done, state == ST_FAIL, state == ST_RUN, 1'b0, state};
          default:  reg_rdata_o <= 32'h0;
        endcase
      end
    end
  end

  // ==========================================================
  // SPI master, mode 0, command MSB first, data LSB first
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      sclk   <= 1'b0;
      txsh   <= 32'h0;
      txn    <= 6'h0;
      rxn    <= 3'h0;
      rxsh   <= 8'h0;
      spi_bv <= 1'b0;
      spi_bd <= 8'h0;
    end else if (clk_en_i) begin
      spi_bv <= 1'b0;
      if (state == ST_DECIDE) begin
        txsh <= {SPI_READ_CMD, SPI_ADDR0};
        sclk <= 1'b0;
        txn  <= 6'h0;
        rxn  <= 3'h0;
      end else if (state == ST_SPI && half_tick && (!ld_done || sclk)) begin
        // Last pulse is finished after the CRC byte so clock idles low
        sclk <= ~sclk;
        if (!sclk) begin
          if (txn != 6'h20) txn <= txn + 6'h01;
          else begin
            rxsh <= {pin_s2[0], rxsh[7:1]};
            rxn  <= rxn + 3'h1;
            if (rxn == 3'h7) begin
              spi_bv <= 1'b1;
              spi_bd <= {pin_s2[0], rxsh[7:1]};
            end
          end
        end else begin
          txsh <= {txsh[30:0], 1'b0};
        end
      end else if (state != ST_SPI) begin
        sclk <= 1'b0;
      end
    end
  end

  assign spi_boot_clock_pin_o  = sclk;
  assign spi_boot_mosi_pin_o   = txsh[31];
  // Select held until the clock is low again, so no deselect with clock high
  assign spi_boot_select_pin_o = !(state == ST_SPI && (!ld_done || sclk));

  // ==========================================================
  // Link receiver: 9-bit tokens, control flag first, sampled on rx wire 1 rise
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      lr_sh   <= 9'h0;
      lr_n    <= 4'h0;
      tok_v   <= 1'b0;
      tok_ctl <= 1'b0;
      tok_d   <= 8'h0;
    end else if (clk_en_i) begin
      tok_v <= 1'b0;
      if (!chan_busy) begin
        lr_n <= 4'h0;
      end else if (pin_s2[2] && !rx1_prev) begin
        lr_sh <= {pin_s2[1], lr_sh[8:1]};
        lr_n  <= (lr_n == 4'h8) ? 4'h0 : lr_n + 4'h1;
        if (lr_n == 4'h8) begin
          tok_v   <= 1'b1;
          tok_ctl <= lr_sh[1];
          tok_d   <= {pin_s2[1], lr_sh[8:2]};
        end
      end
    end
  end

  // Acknowledge channel word, least significant byte first
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      ack  <= 32'h0;
      ackn <= 3'h0;
    end else if (clk_en_i) begin
      if (state == ST_LNKACK && tok_v && !tok_ctl) begin
        ack  <= {tok_d, ack[31:8]};
        ackn <= ackn + 3'h1;
      end
    end
  end

  // Link transmitter: END token to the acknowledge channel
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      lt_sh  <= 9'h0;
      lt_n   <= 4'h0;
      lt_clk <= 1'b0;
    end else if (clk_en_i) begin
      if (state != ST_LNKTX) begin
        lt_sh  <= {TOK_END, 1'b1};
        lt_n   <= 4'h0;
        lt_clk <= 1'b0;
      end else if (half_tick) begin
        lt_clk <= ~lt_clk;
        if (lt_clk) begin
          lt_sh <= {1'b0, lt_sh[8:1]};
          lt_n  <= lt_n + 4'h1;
        end
      end
    end
  end

  assign link_tx_wire_0_o = (state == ST_LNKTX) & lt_sh[0];
  assign link_tx_wire_1_o = (state == ST_LNKTX) & lt_clk;

  // ==========================================================
  // OTP reader: security row first, then image rows from zero
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      opos <= 3'h0;
      orow <= OTP_IMG_ROW;
      owd  <= 32'h0;
    end else if (clk_en_i) begin
      if (state == ST_OTP && !ld_done) begin
        opos <= (opos == 3'h5) ? 3'h0 : opos + 3'h1;
        if (opos == 3'h0) orow <= orow + 11'h001;
        if (opos == 3'h1) owd <= otp_data_i;
        else owd <= {8'h0, owd[31:8]};
      end
    end
  end

  assign otp_rd_o   = (state == ST_SECLD && tmr == 12'h000) || (state == ST_OTP && opos == 3'h0 && !ld_done);
  assign otp_addr_o = (state == ST_SECLD) ? OTP_SEC_ROW : orow;

  // Byte source selection
  always_comb begin
    byte_v = 1'b0;
    byte_d = 8'h0;
    if (state == ST_SPI) begin
      byte_v = spi_bv;
      byte_d = spi_bd;
    end else if (state == ST_OTP) begin
      byte_v = opos >= 3'h2;
      byte_d = owd[7:0];
    end else if (state == ST_LNKIMG) begin
      byte_v = tok_v && !tok_ctl;
      byte_d = tok_d;
    end
    byte_v = byte_v && !ld_done;
  end

  // ==========================================================
  // Image loader: count, program words, CRC word
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      fld      <= 2'h0;
      bidx     <= 2'h0;
      wsh      <= 32'h0;
      left     <= 32'h0;
      crc      <= CRC_INIT;
      img_crc  <= 32'h0;
      ram_addr <= 14'h0;
      ld_done  <= 1'b0;
      ram_wr_o <= '0;
    end else if (clk_en_i) begin
      ram_wr_o.we <= 1'b0;
      if (state == ST_DECIDE) begin
        fld      <= 2'h0;
        bidx     <= 2'h0;
        crc      <= CRC_INIT;
        ram_addr <= BOOT_ADDR[15:2];
        ld_done  <= 1'b0;
      end else if (byte_v) begin
        wsh  <= {byte_d, wsh[31:8]};
        bidx <= bidx + 2'h1;
        if (fld != 2'h2) crc <= crc_byte(crc, byte_d);
        if (bidx == 2'h3) begin
          unique case (fld)
            2'h0: begin
              left <= {byte_d, wsh[31:8]};
              fld  <= ({byte_d, wsh[31:8]} == 32'h0) ? 2'h2 : 2'h1;
            end
            2'h1: begin
              ram_wr_o <= '{we: 1'b1, addr: ram_addr, data: {byte_d, wsh[31:8]}};
              ram_addr <= ram_addr + 14'h0001;
              left     <= left - 32'h1;
              if (left == 32'h1) fld <= 2'h2;
            end
            default: begin
              img_crc <= {byte_d, wsh[31:8]};
              ld_done <= 1'b1;
            end
          endcase
        end
      end
    end
  end

  // Core start at the load address once checked
  assign core_start_o = (state == ST_RUN);
  assign core_pc_o    = BOOT_ADDR;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_decide_otp;
    clk_en_i && state == ST_DECIDE && sec[SEC_OTP_BOOT];
  endsequence
  sequence s_decide_strap(logic [1:0] m);
    clk_en_i && state == ST_DECIDE && !sec[SEC_OTP_BOOT] && strap_s2 == m;
  endsequence
  sequence s_bad_crc;
    clk_en_i && state == ST_CHECK && img_crc != CRC_SKIP && ~crc != img_crc;
  endsequence

  a_pins_float: assert property (state == ST_POR |-> !spi_oe_o && !link_tx_oe_o && !gpio_pull_en_o)
    else $error("pads driven before boot delay");
  a_secure_boot: assert property (s_decide_otp |=> state == ST_OTP)
    else $error("secure boot did not select OTP");
  a_strap_spi: assert property (s_decide_strap(STRAP_SPI) |=> state == ST_SPI)
    else $error("SPI strap not honoured");
  a_strap_link: assert property (s_decide_strap(STRAP_LINK) |=> state == ST_LNKEN)
    else $error("link strap not honoured");
  a_strap_rsvd: assert property (s_decide_strap(2'h1) |=> state == ST_IDLE ##1 spi_boot_select_pin_o)
    else $error("reserved strap started a transfer");
  a_crc_stop: assert property (s_bad_crc |=> state == ST_FAIL ##1 !core_start_o)
    else $error("bad image was started");
  a_first_word: assert property ($rose(ram_wr_o.we) && $past(fld) == 2'h1 && $past(left) != 32'h0
                                 && !$past(ram_addr[0]) |-> ram_wr_o.addr == $past(ram_addr))
    else $error("RAM write address mismatch");
  a_spi_select: assert property (state == ST_SPI && !ld_done |-> !spi_boot_select_pin_o && spi_oe_o)
    else $error("flash not selected during SPI boot");
  a_gate_jtag: assert property (clk_en_i && state == ST_SECLD && tmr == 12'h001
                                |=> sec_gate_o.jtag_off == $past(otp_data_i[SEC_JTAG_OFF])
                                && sec_gate_o.debug_pin_off == $past(otp_data_i[SEC_DEBUG_OFF]))
    else $error("security gate mismatch");
  a_link_enable: assert property (clk_en_i && state == ST_LNKEN && next_state == ST_LNKACK
                                  |=> !link_pd_en_o && link_tx_oe_o && !link_tx_wire_0_o)
    else $error("link not enabled correctly");
endmodule // bil_boot_loader

// ### testbench/bil_flash_model.sv
`timescale 1ns/1ps
// ==========================================
// SPI flash seen from the boot master
module bil_flash_model (
  // SPI pins
  input  wire logic        select_n_i,
  input  wire logic        sclk_i,
  input  wire logic        mosi_i,
  output logic             miso_o,
  // Captured command and address
  output logic [31:0]      cmd_o
);
  logic [7:0] mem [0:63];
  int         bits = 0;
  initial miso_o = 1'b0;
  // Command bits taken on rising edges, MSB first
  always @(posedge sclk_i or posedge select_n_i) begin
    if (select_n_i) bits <= 0;
    else begin
      if (bits < 32) cmd_o <= {cmd_o[30:0], mosi_i};
      bits <= bits + 1;
    end
  end
  // Data changes on falling edges, LSB first; a released line shows the inverse
  always @(negedge sclk_i or posedge select_n_i) begin
    if (select_n_i) miso_o <= ~miso_o;
    else if (bits >= 32) miso_o <= mem[(bits - 32) / 8][(bits - 32) % 8];
  end
endmodule // bil_flash_model

// ### testbench/tb.sv
`timescale 1ns/1ps
module tb;
  import bil_pkg::*;
  // ==========================================
  // Stimulus and observed signals
  logic          clk_i = 1'b0;
  logic          reset_n_i = 1'b0;
  logic [1:0]    strap_mode_i = 2'h0;
  logic [3:0]    reg_addr_i = 4'h0;
  logic [31:0]   reg_wdata_i = 32'h0;
  logic          reg_wr_i = 1'b0;
  logic          reg_rd_i = 1'b0;
  logic [31:0]   otp_data_i = 32'h0;
  logic [31:0]   reg_rdata_o, core_pc_o, flash_cmd, sec_word, otp_img [0:63];
  logic [10:0]   otp_addr_o;
  bil_ram_wr_t   ram_wr_o;
  bil_sec_gate_t sec_gate_o;
  logic          core_start_o, gpio_pull_en_o, sel_n, sclk, mosi, miso, spi_oe_o, sck_q;
  logic [31:0]   words [$];
  int            bad_count = 0, cmp_count = 0, cyc = 0, seed = 80952, widx = 0, hi_n = 0;
  logic          lrx0 = 1'b0, lrx1 = 1'b0, ltx0, ltx1, ltx_q, lpd, ltx_oe, otp_rd;
  logic [8:0]    tx_sh;
  int            tx_n = 0;
  always #4 clk_i = ~clk_i;
  bil_boot_loader dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .clk_en_i(1'b1), .strap_mode_i(strap_mode_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .otp_rd_o(otp_rd), .otp_addr_o(otp_addr_o), .otp_data_i(otp_data_i),
    .ram_wr_o(ram_wr_o), .core_start_o(core_start_o), .core_pc_o(core_pc_o), .sec_gate_o(sec_gate_o),
    .gpio_pull_en_o(gpio_pull_en_o), .link_pd_en_o(lpd), .spi_boot_miso_pin_i(miso),
    .spi_boot_select_pin_o(sel_n), .spi_boot_clock_pin_o(sclk), .spi_boot_mosi_pin_o(mosi),
    .spi_oe_o(spi_oe_o), .link_tx_wire_0_o(ltx0), .link_tx_wire_1_o(ltx1), .link_tx_oe_o(ltx_oe),
    .link_rx_wire_0_i(lrx0), .link_rx_wire_1_i(lrx1));
  bil_flash_model flash_u (.select_n_i(sel_n), .sclk_i(sclk), .mosi_i(mosi), .miso_o(miso), .cmd_o(flash_cmd));
  // ==========================================
  // Checking and closing
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic conclude();
    if (bad_count == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // OTP answers one cycle after the address, RAM writes and SPI clock watched
  always @(posedge clk_i) begin
    if (otp_rd === 1'b1) otp_data_i <= (otp_addr_o == OTP_SEC_ROW) ? sec_word : otp_img[otp_addr_o[5:0]];
    cyc <= cyc + 1;
    sck_q <= sclk;
    ltx_q <= ltx1;
    if (ltx1 === 1'b1 && ltx_q === 1'b0) begin
      tx_sh <= {ltx0, tx_sh[8:1]};
      tx_n++;
    end
    if (cyc == 100000) begin
      bad_count++;
      conclude();
    end
    if (ram_wr_o.we === 1'b1) begin
      check("ram_addr", 32'(ram_wr_o.addr), 32'(widx));
      check("ram_data", ram_wr_o.data, widx < words.size() ? words[widx] : 32'hXXXXXXXX);
      widx++;
    end
    if (sclk === 1'b1) hi_n++;
    else if (sck_q === 1'b1) begin
      check("sclk_high", 32'(hi_n), 32'(HALF_CYC));
      hi_n = 0;
    end
    if (sel_n === 1'b1 && sclk !== 1'b0) check("sclk_idle", 32'(sclk), 32'h0);
  end
  // ==========================================
  // Image builder: mode 0 good CRC, 1 skip value, 2 corrupt CRC
  function automatic logic [31:0] crc_step(logic [31:0] c, logic [7:0] b);
    c = c ^ {24'h0, b};
    for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
    return c;
  endfunction
  task automatic build(input int n, input int mode);
    logic [31:0] img [$];
    logic [31:0] c;
    c = CRC_INIT;
    words = {};
    widx = 0;
    img.push_back(32'(n));
    for (int i = 0; i < n; i++) words.push_back($random(seed));
    img = {img, words};
    foreach (img[i]) for (int b = 0; b < 4; b++) c = crc_step(c, img[i][8*b +: 8]);
    img.push_back(mode == 0 ? ~c : mode == 1 ? CRC_SKIP : c);
    foreach (img[i]) begin
      otp_img[i] = img[i];
      for (int b = 0; b < 4; b++) flash_u.mem[4*i+b] = img[i][8*b +: 8];
    end
  endtask
  // Reset, boot and judge the outcome
  task automatic boot(input logic [1:0] strap, input logic [31:0] sec, input logic go, input int lim);
    int pull_at;
    pull_at = -1;
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    strap_mode_i <= strap;
    sec_word <= sec;
    repeat (2) @(posedge clk_i);
    check("oe_in_reset", 32'({gpio_pull_en_o, spi_oe_o, sel_n}), 32'h1);
    reset_n_i <= 1'b1;
    for (int i = 0; i < lim && core_start_o !== 1'b1; i++) begin
      @(posedge clk_i);
      if (pull_at < 0 && gpio_pull_en_o === 1'b1) pull_at = i;
    end
    #1 check("pull_delay", 32'(pull_at >= 1873 && pull_at <= 18750), 32'h1);
    check("core_start", 32'(core_start_o), 32'(go));
    check("select_end", 32'(sel_n), 32'h1);
    if (go) check("core_pc", core_pc_o, BOOT_ADDR);
  endtask
  task automatic reg_op(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= wr;
    reg_rd_i <= ~wr;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b0;
    #1;
  endtask
  // Remote sender: flag then data LSB first, one bit per 64 ns strobe period
  task automatic send_tok(input logic ctl, input logic [7:0] d);
    logic [8:0] t;
    t = {d, ctl};
    for (int k = 0; k < 9; k++) begin
      @(posedge clk_i);
      lrx0 <= t[k];
      lrx1 <= 1'b0;
      repeat (4) @(posedge clk_i);
      lrx1 <= 1'b1;
      repeat (3) @(posedge clk_i);
    end
  endtask
  // ==========================================
  // Scenarios
  initial begin
    logic [31:0] s;
    sec_word = 32'h0;
    build(3, 0);
    boot(STRAP_SPI, 32'h0, 1'b1, 20000);
    check("word_count", 32'(widx), 32'h3);
    check("flash_cmd", flash_cmd, {SPI_READ_CMD, SPI_ADDR0});
    build(0, 1);
    boot(STRAP_SPI, 32'h0, 1'b1, 20000);
    build(2, 2);
    boot(STRAP_SPI, 32'h0, 1'b0, 20000);
    for (int m = 0; m < 2; m++) begin
      s = m ? $random(seed) & 32'hFFFF0000 : ACK_NULL;
      build(2, 0);
      fork
        boot(STRAP_LINK, 32'h0, 1'b1, 6000);
        begin
          repeat (2000) @(posedge clk_i);
          for (int i = 0; i < 20; i++) send_tok(1'b0, i < 4 ? s[8*i +: 8] : otp_img[i/4-1][8*(i%4) +: 8]);
          send_tok(1'b1, TOK_END);
          @(posedge clk_i);
          lrx1 <= 1'b0;
        end
      join
      check("link_words", 32'(widx), 32'h2);
      check("link_pads", 32'({lpd, ltx_oe}), 32'h1);
      check("end_bits", 32'(tx_n), 32'(9 * m));
      if (m) check("end_token", 32'(tx_sh), 32'({TOK_END, 1'b1}));
    end
    for (int m = 0; m < 2; m++) begin
      build(1, 0);
      boot(2'(m), 32'h0, 1'b0, 3000);
      check("idle_writes", 32'(widx) | 32'(spi_oe_o), 32'h0);
      if (m == 1) begin
        @(posedge clk_i);
        strap_mode_i <= STRAP_SPI;
        reg_op(1'b1, REG_CTRL, 32'h1);
        for (int i = 0; i < 12000 && core_start_o !== 1'b1; i++) @(posedge clk_i);
        #1 check("kick_boot", 32'(core_start_o) | (32'(widx) << 1), 32'h3);
      end
    end
    s = $random(seed) | 32'h20;
    build(4, 0);
    boot(2'h1, s, 1'b1, 3000);
    check("otp_words", 32'(widx), 32'h4);
    reg_op(1'b0, REG_STAT, 32'h0);
    check("status", reg_rdata_o, 32'h00029000);
    check("sec_gate", 32'(sec_gate_o), 32'({s[0], s[1], s[7], s[11:8] | {4{s[12]}}, s[12], s[13], s[14], s[31:22]}));
    reg_op(1'b0, REG_SEC, 32'h0);
    check("sec_read", reg_rdata_o, s);
    reg_op(1'b1, REG_SEC, ~s);
    reg_op(1'b0, REG_SEC, 32'h0);
    check("sec_gp_write", reg_rdata_o, {s[31:22], ~s[21:15], s[14:0]});
    reg_op(1'b0, 4'hC, 32'h0);
    check("unmapped", reg_rdata_o, 32'h0);
    conclude();
  end
endmodule // tb
